// file: design/daa_intl_defines.vh
`ifndef DAA_INTL_DEFINES_VH
`define DAA_INTL_DEFINES_VH
// ****************************************
// register byte addresses (offsets multiples of four: index times four)
// ****************************************
`define CAL_PROTECT_IDX      8'h11
`define SCALE_TERM_IDX       8'h12
`define CAL_PROTECT_ADDR     12'h044
`define SCALE_TERM_ADDR      12'h048
`define IRQ_STATUS_ADDR      12'h080
`define IRQ_MASK_ADDR        12'h084
`define LINE_CTRL_ADDR       12'h088
`define LINE_STATUS_ADDR     12'h08c
// ****************************************
// first control register fields
// ****************************************
`define F_MANUAL_CAL         6
`define F_AUTO_CAL_DIS       5
`define F_CURRENT_LIMIT      4
`define F_OVERLOAD_EN        3
`define F_BILLING_EN         2
`define F_RX_OVERLOAD        1
`define F_BILLING_SEEN       0
// ****************************************
// second control register fields
// ****************************************
`define F_FULL_SCALE         7
`define F_TONE_HEADROOM      6
`define F_FORCE_ALT          5
`define F_LINE_VOLT_ADJ      4
// ****************************************
// status / interrupt bits
// ****************************************
`define S_RX_OVERLOAD        0
`define S_BILLING_SEEN       1
`define S_OVERLOAD_DET       2
// ****************************************
// codes and reset values
// ****************************************
`define DCT_STANDARD         2'h2
`define DCT_CURRENT_LIMIT    2'h3
`define SENSE_ALL_ONES       5'h1f
`define CAL_PROTECT_RST      8'h00
`define SCALE_TERM_RST       8'h00
`define IRQ_MASK_RST         3'h0
`define LINE_CTRL_RST        2'h2
`endif

// file: design/daa_intl_ctrl_regs.v
`timescale 1ns/100ps
// What this block does
// R1 - writing one starts a calibration cycle
// R2 - disable bit blocks automatic calibration
// R3 - current limit only in limiting mode
// R4 - off-hook overload at full sense: protect, flag
// R5 - software enables protection 25 ms after off-hook
// R6 - billing tone rising while protected: change termination
// R7 - receive overload flag sticky, write zero clears
// R8 - billing tone flag sticky, write zero clears
// R9 - full scale bit raises converter full scale
// R10 - headroom bit raises tone dialing headroom
// R11 - software sets headroom for weak lines
// R12 - force bit in standard mode: alternate termination
// R13 - adjust bit shifts tip-ring line voltage
// R14 - termination codes: 10 standard, 11 limiting
// R15 - reserved top bit reads zero
`include "daa_intl_defines.vh"

module daa_intl_ctrl_regs (
  // clock and reset
  input  wire        CLK_I,
  input  wire        RESETN_I,
  // apb slave
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [11:0] PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O,
  // line side status, asynchronous
  input  wire        OFF_HOOK_I,
  input  wire [4:0]  LINE_SENSE_VALUE_I,
  input  wire        RX_BELOW_GROUND_I,
  input  wire        BILLING_TONE_I,
  // line side controls
  output reg         CAL_START_O,
  output reg         AUTO_CAL_EN_O,
  output reg         CURRENT_LIMIT_O,
  output reg         PROTECT_TERM_O,
  output reg         BILLING_TERM_O,
  output reg         FULL_SCALE_O,
  output reg         TONE_HEADROOM_O,
  output reg  [1:0]  TERM_MODE_O,
  output reg         LINE_VOLT_ADJ_O,
  // interrupt
  output reg         IRQ_O
);

  // ****************************************
  // input synchronisers
  // ****************************************
  // three stages; a change counts when stages two and three agree
  reg [7:0] s1_r;
  reg [7:0] s2_r;
  reg [7:0] s3_r;
  reg [7:0] filt_r;
  wire [7:0] raw = {RX_BELOW_GROUND_I, BILLING_TONE_I, OFF_HOOK_I, LINE_SENSE_VALUE_I};

  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s1_r   <= 8'h00;
      s2_r   <= 8'h00;
      s3_r   <= 8'h00;
      filt_r <= 8'h00;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
    end
  end

  wire [4:0] sense    = filt_r[4:0];
  wire       off_hook = filt_r[5];
  wire       bill_in  = filt_r[6];
  wire       rx_ovl   = filt_r[7];

  // ****************************************
  // register storage
  // ****************************************
  reg  [7:0] cal_protect_r;
  reg  [7:0] scale_term_r;
  reg  [2:0] irq_status_r;
  reg  [2:0] irq_mask_r;
  reg  [1:0] dc_termination_select_r;
  reg        bill_prev_r;
  reg        overload_detected_r;
  reg        billing_latched_r;

  wire setup     = PSEL_I & ~PENABLE_I;
  wire wr_access = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;

  function hit;
    input [11:0] a;
    input [11:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  wire wr_cal  = wr_access & hit(PADDR_I, `CAL_PROTECT_ADDR);
  wire wr_term = wr_access & hit(PADDR_I, `SCALE_TERM_ADDR);
  wire wr_irq  = wr_access & hit(PADDR_I, `IRQ_STATUS_ADDR);
  wire wr_mask = wr_access & hit(PADDR_I, `IRQ_MASK_ADDR);
  wire wr_line = wr_access & hit(PADDR_I, `LINE_CTRL_ADDR);

  wire bill_rise = bill_in & ~bill_prev_r;
  wire ovl_cond  = off_hook & cal_protect_r[`F_OVERLOAD_EN] & (sense == `SENSE_ALL_ONES); // R4

  // ****************************************
  // first control register
  // ****************************************
  reg [7:0] cal_nxt;

  always @* begin
    cal_nxt = cal_protect_r;
    if (wr_cal) begin
      cal_nxt[6:2] = PWDATA_I[6:2];
      // flags only clear by a written zero
      if (!PWDATA_I[`F_RX_OVERLOAD])  cal_nxt[`F_RX_OVERLOAD]  = 1'b0; // R7
      if (!PWDATA_I[`F_BILLING_SEEN]) cal_nxt[`F_BILLING_SEEN] = 1'b0; // R8
    end
    // set wins over a clear in the same cycle
    if (rx_ovl)    cal_nxt[`F_RX_OVERLOAD]  = 1'b1; // R7
    if (bill_rise) cal_nxt[`F_BILLING_SEEN] = 1'b1; // R8
    cal_nxt[7] = 1'b0; // R15
  end

  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cal_protect_r           <= `CAL_PROTECT_RST;
      scale_term_r            <= `SCALE_TERM_RST;
      dc_termination_select_r <= `LINE_CTRL_RST;
      irq_mask_r              <= `IRQ_MASK_RST;
      bill_prev_r             <= 1'b0;
    end else begin
      cal_protect_r <= cal_nxt;
      bill_prev_r   <= bill_in;
      if (wr_term) begin
        scale_term_r <= {PWDATA_I[7:4], 4'h0};
      end
      if (wr_line) begin
        dc_termination_select_r <= PWDATA_I[1:0];
      end
      if (wr_mask) begin
        irq_mask_r <= PWDATA_I[2:0];
      end
    end
  end

  // ****************************************
  // protection state
  // ****************************************
  // protection holds until software drops the enable bit
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      overload_detected_r <= 1'b0;
      billing_latched_r   <= 1'b0;
    end else begin
      if (ovl_cond) begin
        overload_detected_r <= 1'b1; // R4
      end else if (!cal_protect_r[`F_OVERLOAD_EN]) begin
        overload_detected_r <= 1'b0; // R5
      end
      if (off_hook & cal_protect_r[`F_BILLING_EN] & bill_rise) begin
        billing_latched_r <= 1'b1; // R6
      end else if (!cal_protect_r[`F_BILLING_EN] | !off_hook) begin
        billing_latched_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // interrupt status
  // ****************************************
  wire [2:0] events = {ovl_cond & ~overload_detected_r, bill_rise, rx_ovl};
  wire [2:0] irq_nxt = (irq_status_r & ~({3{wr_irq}} & PWDATA_I[2:0])) | events;

  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      irq_status_r <= 3'h0;
      IRQ_O        <= 1'b0;
    end else begin
      irq_status_r <= irq_nxt;
      IRQ_O        <= |(irq_nxt & irq_mask_r);
    end
  end

  // ****************************************
  // line side outputs
  // ****************************************
  wire       limit_mode = (dc_termination_select_r == `DCT_CURRENT_LIMIT); // R14
  wire       std_mode   = (dc_termination_select_r == `DCT_STANDARD);      // R14
  // alternate termination is reported as code 01 to the analog side
  wire [1:0] term_nxt   = (std_mode & scale_term_r[`F_FORCE_ALT]) ? 2'h1 // R12
                          : dc_termination_select_r;

  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      CAL_START_O     <= 1'b0;
      AUTO_CAL_EN_O   <= 1'b1;
      CURRENT_LIMIT_O <= 1'b0;
      PROTECT_TERM_O  <= 1'b0;
      BILLING_TERM_O  <= 1'b0;
      FULL_SCALE_O    <= 1'b0;
      TONE_HEADROOM_O <= 1'b0;
      TERM_MODE_O     <= `LINE_CTRL_RST;
      LINE_VOLT_ADJ_O <= 1'b0;
    end else begin
      // one pulse per written one; the bit itself reads back as stored
      CAL_START_O     <= wr_cal & PWDATA_I[`F_MANUAL_CAL];             // R1
      AUTO_CAL_EN_O   <= ~cal_protect_r[`F_AUTO_CAL_DIS];              // R2
      CURRENT_LIMIT_O <= limit_mode & cal_protect_r[`F_CURRENT_LIMIT]; // R3
      PROTECT_TERM_O  <= overload_detected_r;                          // R4
      BILLING_TERM_O  <= billing_latched_r;                            // R6
      FULL_SCALE_O    <= scale_term_r[`F_FULL_SCALE];                  // R9
      TONE_HEADROOM_O <= scale_term_r[`F_TONE_HEADROOM];               // R10
      TERM_MODE_O     <= term_nxt;                                     // R12
      LINE_VOLT_ADJ_O <= scale_term_r[`F_LINE_VOLT_ADJ];               // R13
    end
  end

  // ****************************************
  // apb read path
  // ****************************************
  // no wait state: answer lands in the cycle after setup
  reg [31:0] rd_nxt;
  reg        err_nxt;

  always @* begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    case (PADDR_I)
      `CAL_PROTECT_ADDR: rd_nxt[7:0] = cal_protect_r;
      `SCALE_TERM_ADDR:  rd_nxt[7:0] = scale_term_r;
      `IRQ_STATUS_ADDR:  rd_nxt[2:0] = irq_status_r;
      `IRQ_MASK_ADDR:    rd_nxt[2:0] = irq_mask_r;
      `LINE_CTRL_ADDR:   rd_nxt[1:0] = dc_termination_select_r;
      `LINE_STATUS_ADDR: rd_nxt[7:0] = {billing_latched_r, overload_detected_r, off_hook, sense};
      default:           err_nxt = 1'b1;
    endcase
  end

  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      PRDATA_O  <= 32'h0000_0000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= setup;
      PSLVERR_O <= setup & err_nxt;
      PRDATA_O  <= (setup & ~PWRITE_I) ? rd_nxt : 32'h0000_0000;
    end
  end

endmodule

// file: test/daa_intl_sva.sv
`timescale 1ns/100ps
// ****
// port checker
// ****
module daa_intl_sva (
  input wire        CLK_I,
  input wire        RESETN_I,
  input wire        PSEL_I,
  input wire        PENABLE_I,
  input wire        PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  input wire [31:0] PRDATA_O,
  input wire        PREADY_O,
  input wire        PSLVERR_O,
  input wire        OFF_HOOK_I,
  input wire        CAL_START_O,
  input wire        AUTO_CAL_EN_O,
  input wire        CURRENT_LIMIT_O,
  input wire        BILLING_TERM_O,
  input wire [1:0]  TERM_MODE_O,
  input wire        IRQ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  sequence s_setup;
    PSEL_I && !PENABLE_I;
  endsequence
  sequence s_wr17;
    PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == 12'h044;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> PREADY_O)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held too long");
  a_err_with_ready: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  a_cal_on_write: assert property (s_wr17 ##0 PWDATA_I[6] |-> ##[1:2] CAL_START_O)
    else $error("no calibration pulse");
  a_limit_needs_mode: assert property (CURRENT_LIMIT_O |-> TERM_MODE_O == 2'h3)
    else $error("limit outside limiting mode");
  a_reset_levels: assert property ($rose(RESETN_I) |-> AUTO_CAL_EN_O && TERM_MODE_O == 2'h2)
    else $error("bad levels after reset");
  a_reserved_zero: assert property (PREADY_O && !PWRITE_I && PADDR_I == 12'h044
    |-> PRDATA_O[31:7] == 25'h0)
    else $error("reserved bit read nonzero");
  a_bill_onhook: assert property (!OFF_HOOK_I [*8] |-> !BILLING_TERM_O)
    else $error("billing termination while on hook");
endmodule

bind daa_intl_ctrl_regs daa_intl_sva chk (.CLK_I, .RESETN_I, .PSEL_I, .PENABLE_I,
  .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .OFF_HOOK_I,
  .CAL_START_O, .AUTO_CAL_EN_O, .CURRENT_LIMIT_O, .BILLING_TERM_O, .TERM_MODE_O, .IRQ_O);

// file: test/line_side_model.sv
`timescale 1ns/100ps
// ****
// line side stand-in
// ****
module line_side_model (
  input  wire       CLK_I,
  input  wire       off_i,
  input  wire [4:0] sense_i,
  input  wire       rx_i,
  input  wire       tone_i,
  input  wire       prot_i,
  output reg        OFF_HOOK_I = 1'b0,
  output reg  [4:0] LINE_SENSE_VALUE_I = 5'h00,
  output reg        RX_BELOW_GROUND_I = 1'b0,
  output reg        BILLING_TONE_I = 1'b0
);
  // protective termination drags the sense off full scale, so no oscillation
  always @(posedge CLK_I) begin
    OFF_HOOK_I         <= off_i;
    LINE_SENSE_VALUE_I <= !off_i ? 5'h00 : (prot_i ? 5'h08 : sense_i);
    RX_BELOW_GROUND_I  <= rx_i;
    BILLING_TONE_I     <= tone_i;
  end
endmodule

// file: test/daa_international_control_regs_bench.sv
`timescale 1ns/100ps
// ****
// bench
// ****
module daa_international_control_regs_bench;
  logic CLK_I = 0, RESETN_I = 0, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
  logic [11:0] PADDR_I = 0;
  logic [31:0] PWDATA_I = 0, rd;
  logic off_c = 0, rx_c = 0, tone_c = 0, er;
  logic [4:0] sense_c = 0;
  wire [31:0] PRDATA_O;
  wire [4:0] LINE_SENSE_VALUE_I;
  wire [1:0] TERM_MODE_O;
  wire PREADY_O, PSLVERR_O, OFF_HOOK_I, RX_BELOW_GROUND_I, BILLING_TONE_I, CAL_START_O;
  wire AUTO_CAL_EN_O, CURRENT_LIMIT_O, PROTECT_TERM_O, BILLING_TERM_O, FULL_SCALE_O;
  wire TONE_HEADROOM_O, LINE_VOLT_ADJ_O, IRQ_O;
  integer err_count = 0, checks_done = 0;
  always #5 CLK_I = ~CLK_I;
  daa_intl_ctrl_regs dut (.CLK_I, .RESETN_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
    .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .OFF_HOOK_I, .LINE_SENSE_VALUE_I,
    .RX_BELOW_GROUND_I, .BILLING_TONE_I, .CAL_START_O, .AUTO_CAL_EN_O, .CURRENT_LIMIT_O,
    .PROTECT_TERM_O, .BILLING_TERM_O, .FULL_SCALE_O, .TONE_HEADROOM_O, .TERM_MODE_O,
    .LINE_VOLT_ADJ_O, .IRQ_O);
  line_side_model line (.CLK_I, .off_i(off_c), .sense_i(sense_c), .rx_i(rx_c),
    .tone_i(tone_c), .prot_i(PROTECT_TERM_O), .OFF_HOOK_I, .LINE_SENSE_VALUE_I,
    .RX_BELOW_GROUND_I, .BILLING_TONE_I);
  task close_out;
    begin
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    begin
      checks_done++;
      if (g !== e) begin
        err_count++;
        $display("Error %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task apb(input logic w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge CLK_I);
      PSEL_I <= 1; PWRITE_I <= w; PADDR_I <= a; PWDATA_I <= d;
      @(posedge CLK_I);
      PENABLE_I <= 1;
      // ready, data and error are taken at the edge that sees ready high
      @(posedge CLK_I);
      while (PREADY_O !== 1'b1 && n < 20) begin
        @(posedge CLK_I);
        n++;
      end
      if (n == 20) begin
        err_count++;
        close_out;
      end
      rd = PRDATA_O;
      er = PSLVERR_O;
      PSEL_I <= 0;
      PENABLE_I <= 0;
    end
  endtask
  // input sync plus output register, with margin
  task settle;
    begin
      repeat (8) @(posedge CLK_I);
      #1;
    end
  endtask
  task t_base;
    integer k;
    logic s;
    begin
      apb(0, 12'h044, 0); chk("reg17_rst", 0, rd);
      apb(0, 12'h088, 0); chk("dct_rst", 2, rd);
      apb(1, 12'h044, 32'h60); s = 0;
      for (k = 0; k < 4; k++) begin
        #1 if (CAL_START_O === 1'b1) s = 1;
        @(posedge CLK_I);
      end
      chk("cal_start", 1, s);
      apb(0, 12'h044, 0); chk("reg17", 32'h60, rd);
      settle; chk("auto_cal_off", 0, AUTO_CAL_EN_O);
      apb(1, 12'h044, 0); settle; chk("auto_cal_on", 1, AUTO_CAL_EN_O);
      apb(0, 12'h0f0, 0); chk("slverr", 1, er); chk("unmapped", 0, rd);
    end
  endtask
  task t_term;
    begin
      apb(1, 12'h044, 32'h10); settle; chk("limit_std", 0, CURRENT_LIMIT_O);
      apb(1, 12'h088, 3); settle; chk("limit_lim", 1, CURRENT_LIMIT_O);
      apb(1, 12'h048, 32'hff);
      apb(0, 12'h048, 0); chk("reg18", 32'hf0, rd);
      settle; chk("scale", 7, {FULL_SCALE_O, TONE_HEADROOM_O, LINE_VOLT_ADJ_O});
      chk("headroom", 1, TONE_HEADROOM_O);
      chk("volt_adj", 1, LINE_VOLT_ADJ_O);
      chk("term_lim", 3, TERM_MODE_O);
      apb(1, 12'h088, 2); settle; chk("term_force", 1, TERM_MODE_O);
      chk("limit_off", 0, CURRENT_LIMIT_O);
      apb(1, 12'h048, 0); apb(1, 12'h044, 0); settle; chk("term_std", 2, TERM_MODE_O);
    end
  endtask
  task t_flags;
    begin
      apb(1, 12'h084, 3); rx_c <= 1; settle; rx_c <= 0; settle;
      apb(0, 12'h044, 0); chk("rx_flag", 2, rd);
      chk("irq_rx", 1, IRQ_O);
      apb(1, 12'h044, 2); apb(0, 12'h044, 0); chk("rx_keep", 2, rd);
      apb(1, 12'h044, 0); apb(0, 12'h044, 0); chk("rx_clear", 0, rd);
      apb(1, 12'h080, 1); settle; chk("irq_clear", 0, IRQ_O);
      apb(1, 12'h084, 0); tone_c <= 1; settle;
      apb(0, 12'h044, 0); chk("tone_flag", 1, rd);
      chk("irq_masked", 0, IRQ_O);
      apb(1, 12'h084, 2); settle; chk("irq_tone", 1, IRQ_O);
      apb(1, 12'h080, 2); apb(1, 12'h044, 0); tone_c <= 0; settle;
      chk("irq_tone_clr", 0, IRQ_O);
      apb(0, 12'h044, 0); chk("tone_clear", 0, rd);
    end
  endtask
  task t_prot;
    begin
      off_c <= 1; sense_c <= 5'h1f; settle;
      apb(1, 12'h044, 8);
      settle; chk("protect", 1, PROTECT_TERM_O);
      apb(1, 12'h044, 0); settle; chk("protect_off", 0, PROTECT_TERM_O);
      apb(1, 12'h044, 4); tone_c <= 1; settle; chk("bill_term", 1, BILLING_TERM_O);
      off_c <= 0; settle; chk("bill_onhook", 0, BILLING_TERM_O);
      tone_c <= 0; apb(1, 12'h044, 0);
    end
  endtask
  initial begin
    repeat (16) @(posedge CLK_I);
    RESETN_I <= 1;
    t_base;
    t_term;
    t_flags;
    t_prot;
    close_out;
  end
endmodule
